// ---- rtl/ctc_pkg.sv ----
// package for the capture timer counter core: register map, fields, types
// assumes a 32-bit avalon-mm slave with word-aligned registers
package ctc_pkg;

  // register byte offsets
  localparam logic [3:0] CTC_OFS_CTRL   = 4'h0;
  localparam logic [3:0] CTC_OFS_COUNT  = 4'h4;
  localparam logic [3:0] CTC_OFS_PERIOD = 4'h8;
  localparam logic [3:0] CTC_OFS_STAT   = 4'hC;
  localparam logic [4:0] CTC_OFS_MASK   = 5'h10;
  localparam logic [4:0] CTC_OFS_VEC    = 5'h14;

  // control field positions
  localparam int CTC_POS_MODE  = 0;
  localparam int CTC_POS_DIV   = 2;
  localparam int CTC_POS_SRC   = 4;
  localparam int CTC_POS_CLR   = 6;

  // reset values and counting constants
  localparam logic [15:0] CTC_RST_COUNT  = 16'h0000;
  localparam logic [15:0] CTC_RST_PERIOD = 16'h0000;
  localparam logic [15:0] CTC_MAX_COUNT  = 16'hFFFF;
  localparam logic [15:0] CTC_ONE        = 16'h0001;
  localparam logic [2:0]  CTC_DIV_ZERO   = 3'h0;

  // channel count of this variant, three or five
  localparam int CTC_NUM_CH = 3;

  // interrupt vector codes
  localparam logic [3:0] CTC_VEC_NONE = 4'h0;
  localparam logic [3:0] CTC_VEC_OVF  = 4'hE;

  typedef enum logic [1:0]
  {
    CTC_MODE_STOP = 2'h0,
    CTC_MODE_UP   = 2'h1,
    CTC_MODE_CONT = 2'h2,
    CTC_MODE_UPDN = 2'h3
  } ctc_mode_t;

  typedef struct packed
  {
    logic [1:0] src;
    logic [1:0] div;
    ctc_mode_t  mode;
  } ctc_cfg_t;

  typedef struct packed
  {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } ctc_req_t;

endpackage

// ---- rtl/ctc_core.sv ----
// timer/counter core: 16-bit counter, source select, divider, clear, irq
// assumes clock sources are slow pins sampled by ref_clk (20 MHz)
// Function
// RULE1: sixteen-bit counter steps once per selected timer clock edge, up or down.
// RULE2: software reads and writes the count; writes take effect immediately.
// RULE3: counter overflow can raise an interrupt request.
// RULE4: clear bit zeroes count, prescaler and latched direction.
// RULE5: source select picks auxiliary, sub-main, external or alternate clock.
// RULE6: divider passes clock through or divides by two, four or eight.
// RULE7: flags set only when counting reaches a value, never on writes.
// RULE8: three or five channels share the counter, fixed per variant.
// RULE9: interrupts from overflow and separately from each channel.
// RULE10: four operating modes chosen by the mode field.
// RULE11: vector register encodes the highest pending timer interrupt.
// RULE12: asynchronous inputs are latched safely into the cpu clock.
// RULE13: software stops the timer before reconfiguring, except flags and clear.
// RULE14: asynchronous reads are done stopped or by majority vote.
// RULE15: modes: stop, up to period, continuous wrap, up then down.
`timescale 1ns/1ps
module ctc_core
  import ctc_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // timer clock sources
  input  wire logic                  aux_clk,
  input  wire logic                  sub_main_clock,
  input  wire logic                  external_timer_clock,
  input  wire logic                  alternate_external_clock,
  // channel events from the capture/compare units
  input  wire logic [ctc_pkg::CTC_NUM_CH-1:0] ch_event,
  // avalon-mm slave
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // count state to the channels, interrupt
  output logic      [15:0]           count_value,
  output logic                       count_down,
  output logic                       irq
);
  import ctc_pkg::*;

  localparam int NSRC = 4;
  localparam int NST  = NSRC + CTC_NUM_CH;

  // three-stage sampling of each source; stage 0 is read only by stage 1
  logic [NST-1:0] s0_ff, s1_ff, s2_ff, stab_ff;
  logic [NST-1:0] nxt_stab;
  logic [NST-1:0] raw_in;
  assign raw_in = {ch_event, alternate_external_clock, external_timer_clock,
                   sub_main_clock, aux_clk};

  genvar gi;
  generate
    for (gi = 0; gi < NST; gi++)
    begin : g_sync
      // a change counts only once stages one and two agree
      always_comb
      begin
        nxt_stab[gi] = (s1_ff[gi] == s2_ff[gi]) ? s2_ff[gi] : stab_ff[gi];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s0_ff   <= '0;
      s1_ff   <= '0;
      s2_ff   <= '0;
      stab_ff <= '0;
    end
    else
    begin
      s0_ff   <= raw_in;
      s1_ff   <= s0_ff;
      s2_ff   <= s1_ff;
      stab_ff <= nxt_stab; // RULE12
    end
  end

  // register state
  ctc_cfg_t              cfg_ff, nxt_cfg;
  logic [15:0]           cnt_ff, nxt_cnt;
  logic [15:0]           per_ff, nxt_per;
  logic                  dir_ff, nxt_dir;
  logic [2:0]            pre_ff, nxt_pre;
  logic                  tck_ff, nxt_tck;
  logic [NST-1:0]        prev_ff;
  logic [CTC_NUM_CH:0]   stat_ff, nxt_stat;
  logic [CTC_NUM_CH:0]   mask_ff, nxt_mask;
  logic [31:0]           rd_ff, nxt_rd;
  logic                  ack_ff, nxt_ack;
  logic                  wait_ff, nxt_wait;
  logic                  irq_ff, nxt_irq;

  logic                  sel_clk, src_rise, tick;
  logic [2:0]            div_lim;
  logic                  wr_hit, rd_hit, ovf_evt, clr;
  logic [CTC_NUM_CH-1:0] ch_rise;
  logic [3:0]            vec;
  logic [CTC_NUM_CH:0]   pend;

  assign sel_clk  = stab_ff[cfg_ff.src]; // RULE5
  assign src_rise = sel_clk & ~prev_ff[cfg_ff.src];
  assign ch_rise  = stab_ff[NST-1:NSRC] & ~prev_ff[NST-1:NSRC];
  assign div_lim  = 3'((1 << cfg_ff.div) - 1); // RULE6
  // a write commits only at the edge where waitrequest is seen low
  assign wr_hit   = avs_write & ack_ff;
  assign rd_hit   = avs_read & ~ack_ff;
  assign clr      = wr_hit && avs_address == 5'(CTC_OFS_CTRL)
                    && avs_writedata[CTC_POS_CLR];

  // divider: one tick per 1, 2, 4 or 8 source edges
  always_comb
  begin
    nxt_pre = pre_ff;
    nxt_tck = 1'b0;
    if (src_rise)
    begin
      if (pre_ff >= div_lim)
      begin
        nxt_pre = CTC_DIV_ZERO;
        nxt_tck = 1'b1;
      end
      else
      begin
        nxt_pre = 3'(pre_ff + 3'h1);
      end
    end
    if (clr)
    begin
      nxt_pre = CTC_DIV_ZERO; // RULE4
      nxt_tck = 1'b0;
    end
  end
  assign tick = tck_ff;

  // counter and direction; overflow only from counting, not from writes
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    ovf_evt = 1'b0;
    if (tick)
    begin
      unique case (cfg_ff.mode) // RULE10 RULE15
        CTC_MODE_STOP:
        begin
          nxt_cnt = cnt_ff;
        end
        CTC_MODE_UP:
        begin
          if (cnt_ff >= per_ff)
          begin
            nxt_cnt = CTC_RST_COUNT;
            ovf_evt = (cnt_ff == per_ff);
          end
          else
          begin
            nxt_cnt = 16'(cnt_ff + CTC_ONE); // RULE1
          end
        end
        CTC_MODE_CONT:
        begin
          nxt_cnt = 16'(cnt_ff + CTC_ONE);
          ovf_evt = (cnt_ff == CTC_MAX_COUNT);
        end
        CTC_MODE_UPDN:
        begin
          if (!dir_ff)
          begin
            if (cnt_ff >= per_ff)
            begin
              nxt_dir = 1'b1;
              nxt_cnt = 16'(cnt_ff - CTC_ONE);
            end
            else
            begin
              nxt_cnt = 16'(cnt_ff + CTC_ONE);
            end
          end
          else if (cnt_ff == CTC_RST_COUNT)
          begin
            nxt_dir = 1'b0;
            nxt_cnt = CTC_ONE;
          end
          else
          begin
            nxt_cnt = 16'(cnt_ff - CTC_ONE);
            ovf_evt = (cnt_ff == CTC_ONE);
          end
        end
      endcase
    end
    if (wr_hit && avs_address == 5'(CTC_OFS_COUNT))
    begin
      nxt_cnt = avs_writedata[15:0]; // RULE2 RULE7
      ovf_evt = 1'b0;
    end
    if (clr)
    begin
      nxt_cnt = CTC_RST_COUNT; // RULE4
      nxt_dir = 1'b0;
      ovf_evt = 1'b0;
    end
  end

  // interrupt priority: lowest channel first, overflow last
  always_comb
  begin
    pend = stat_ff & mask_ff;
    vec  = CTC_VEC_NONE;
    for (int i = CTC_NUM_CH; i >= 0; i--)
    begin
      if (pend[i])
      begin
        vec = (i == CTC_NUM_CH) ? CTC_VEC_OVF : 4'((i + 1) * 2); // RULE11
      end
    end
  end

  // bus slave: one wait cycle, answer on the second cycle
  always_comb
  begin
    nxt_cfg  = cfg_ff;
    nxt_per  = per_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    nxt_rd   = rd_ff;
    nxt_ack  = (avs_read | avs_write) & ~ack_ff;
    nxt_wait = ~nxt_ack;
    if (wr_hit)
    begin
      unique case (avs_address)
        5'(CTC_OFS_CTRL):
        begin
          nxt_cfg.mode = ctc_mode_t'(avs_writedata[CTC_POS_MODE +: 2]);
          nxt_cfg.div  = avs_writedata[CTC_POS_DIV +: 2];
          nxt_cfg.src  = avs_writedata[CTC_POS_SRC +: 2];
        end
        5'(CTC_OFS_PERIOD): nxt_per = avs_writedata[15:0];
        5'(CTC_OFS_STAT):
          nxt_stat = stat_ff & ~avs_writedata[CTC_NUM_CH:0];
        CTC_OFS_MASK: nxt_mask = avs_writedata[CTC_NUM_CH:0];
        default: nxt_per = per_ff;
      endcase
    end
    // set wins over a write-one clear in the same cycle
    nxt_stat = nxt_stat | {ovf_evt, ch_rise}; // RULE3 RULE8 RULE9
    if (rd_hit)
    begin
      unique case (avs_address)
        5'(CTC_OFS_CTRL):   nxt_rd = 32'({cfg_ff.src, cfg_ff.div,
                                          cfg_ff.mode});
        5'(CTC_OFS_COUNT):  nxt_rd = {16'h0000, cnt_ff}; // RULE2
        5'(CTC_OFS_PERIOD): nxt_rd = {16'h0000, per_ff};
        5'(CTC_OFS_STAT):   nxt_rd = 32'(stat_ff);
        CTC_OFS_MASK:       nxt_rd = 32'(mask_ff);
        CTC_OFS_VEC:        nxt_rd = 32'(vec);
        default:            nxt_rd = 32'h0000_0000;
      endcase
    end
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cfg_ff  <= '{src: 2'h0, div: 2'h0, mode: CTC_MODE_STOP};
      cnt_ff  <= CTC_RST_COUNT;
      per_ff  <= CTC_RST_PERIOD;
      dir_ff  <= 1'b0;
      pre_ff  <= CTC_DIV_ZERO;
      tck_ff  <= 1'b0;
      prev_ff <= '0;
      stat_ff <= '0;
      mask_ff <= '0;
      rd_ff   <= 32'h0000_0000;
      ack_ff  <= 1'b0;
      wait_ff <= 1'b1;
      irq_ff  <= 1'b0;
    end
    else
    begin
      cfg_ff  <= nxt_cfg;
      cnt_ff  <= nxt_cnt;
      per_ff  <= nxt_per;
      dir_ff  <= nxt_dir;
      pre_ff  <= nxt_pre;
      tck_ff  <= nxt_tck;
      prev_ff <= stab_ff;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      rd_ff   <= nxt_rd;
      ack_ff  <= nxt_ack;
      wait_ff <= nxt_wait;
      irq_ff  <= nxt_irq;
    end
  end

  assign avs_readdata    = rd_ff;
  assign avs_waitrequest = wait_ff;
  assign count_value     = cnt_ff;
  assign count_down      = dir_ff;
  assign irq             = irq_ff;

  // checks
  a_cont_wrap: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick && cfg_ff.mode == CTC_MODE_CONT && cnt_ff == CTC_MAX_COUNT
    && !avs_write |=> cnt_ff == CTC_RST_COUNT && stat_ff[CTC_NUM_CH])
    else $error("continuous wrap missed"); // RULE3
  a_clear_all: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clr |=> cnt_ff == CTC_RST_COUNT && pre_ff == CTC_DIV_ZERO && !dir_ff)
    else $error("clear incomplete"); // RULE4
  a_write_cnt: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_hit && avs_address == 5'(CTC_OFS_COUNT) && !clr
    |=> cnt_ff == $past(avs_writedata[15:0]))
    else $error("count write lost"); // RULE2
  a_write_noflag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_hit && avs_address == 5'(CTC_OFS_COUNT) && ch_rise == '0
    && !stat_ff[CTC_NUM_CH] |=> !stat_ff[CTC_NUM_CH])
    else $error("write set overflow flag"); // RULE7
  a_stop_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_ff.mode == CTC_MODE_STOP && !wr_hit |=> $stable(cnt_ff))
    else $error("stopped counter moved"); // RULE15
  a_up_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick && cfg_ff.mode == CTC_MODE_UP && cnt_ff < per_ff && !wr_hit
    |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("up step wrong"); // RULE1
  a_updn_turn: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick && cfg_ff.mode == CTC_MODE_UPDN && !dir_ff && cnt_ff == per_ff
    && per_ff != 16'h0000 && !wr_hit |=> dir_ff)
    else $error("no turn at period"); // RULE10
  a_irq_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    irq == |(stat_ff & mask_ff))
    else $error("irq mismatch"); // RULE9
  a_bus_answer: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late"); // RULE12
  c_cont_ovf: cover property (@(posedge ref_clk)
    tick && cfg_ff.mode == CTC_MODE_CONT && cnt_ff == CTC_MAX_COUNT);
  c_updn_turn: cover property (@(posedge ref_clk) $rose(dir_ff));
  c_irq: cover property (@(posedge ref_clk) $rose(irq));
endmodule // ctc_core

// ---- verif/tb_ctc_core.sv ----
// self-checking bench for the capture timer counter core
// assumes the ctc_pkg register map and one wait cycle per bus access
`timescale 1ns/1ps
module tb_ctc_core;
  import ctc_pkg::*;

  localparam logic [4:0] A_CTRL = {1'b0, CTC_OFS_CTRL};
  localparam logic [4:0] A_CNT  = {1'b0, CTC_OFS_COUNT};
  localparam logic [4:0] A_PER  = {1'b0, CTC_OFS_PERIOD};
  localparam logic [4:0] A_STAT = {1'b0, CTC_OFS_STAT};
  localparam logic [4:0] A_MASK = CTC_OFS_MASK;
  localparam logic [4:0] A_VEC  = CTC_OFS_VEC;

  logic                  ref_clk         = 1'b0;
  logic                  sys_rst         = 1'b1;
  logic [3:0]            src_clk         = 4'h0;
  logic [CTC_NUM_CH-1:0] ch_event        = '0;
  logic [4:0]            avs_address     = 5'h00;
  logic                  avs_read        = 1'b0;
  logic                  avs_write       = 1'b0;
  logic [31:0]           avs_writedata   = 32'h0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [15:0]           count_value;
  logic                  count_down;
  logic                  irq;
  int                    failures        = 0;
  int                    num_checks      = 0;
  int                    cycles          = 0;
  int                    seed            = 32'h75ea;
  logic [31:0]           v;
  logic [31:0]           exp_q[$];
  string                 name_q[$];

  ctc_core ctc_core_inst (
    .ref_clk                  (ref_clk),
    .sys_rst                  (sys_rst),
    .aux_clk                  (src_clk[0]),
    .sub_main_clock           (src_clk[1]),
    .external_timer_clock     (src_clk[2]),
    .alternate_external_clock (src_clk[3]),
    .ch_event                 (ch_event),
    .avs_address              (avs_address),
    .avs_read                 (avs_read),
    .avs_write                (avs_write),
    .avs_writedata            (avs_writedata),
    .avs_readdata             (avs_readdata),
    .avs_waitrequest          (avs_waitrequest),
    .count_value              (count_value),
    .count_down               (count_down),
    .irq                      (irq)
  );

  always #25 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // a hung handshake is cut short here
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      summarize();
    end
  end

  // read results are matched against the oldest note
  always @(posedge ref_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk(name_q.pop_front(), exp_q.pop_front(), avs_readdata);

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic setc(input int m, input int dv, input int sr,
                      input logic clr);
    wr(A_CTRL, {25'h0, clr, sr[1:0], dv[1:0], m[1:0]});
  endtask

  // source edges are slow against ref_clk so the synchroniser sees them
  task automatic ticks(input int s, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      src_clk[s] <= 1'b1;
      repeat (5) @(posedge ref_clk);
      src_clk[s] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    repeat (10) @(posedge ref_clk);
  endtask

  task automatic chan(input logic [CTC_NUM_CH-1:0] p);
    @(posedge ref_clk);
    ch_event <= p;
    repeat (6) @(posedge ref_clk);
    ch_event <= '0;
    repeat (8) @(posedge ref_clk);
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(A_CTRL, 32'h0, "ctrl");
    rd(A_CNT, 32'h0, "count");
    rd(A_VEC, 32'h0, "vector");
    rd(5'h18, 32'h0, "unmapped");
    $display("test reset done");
    repeat (4)
    begin
      v = $random(seed);
      wr(A_CNT, v);
      rd(A_CNT, {16'h0, v[15:0]}, "count");
    end
    $display("test count access done");
    for (int s = 0; s < 4; s++)
      for (int dv = 0; dv < 4; dv++)
      begin
        setc(0, dv, s, 1'b1);
        setc(2, dv, s, 1'b0);
        ticks(s, 16);
        setc(0, dv, s, 1'b0);
        rd(A_CNT, 32'd16 >> dv, "count");
      end
    setc(2, 3, 0, 1'b1);
    ticks(0, 6);
    setc(2, 3, 0, 1'b1);
    ticks(0, 7);
    rd(A_CNT, 32'h0, "count");
    $display("test source and divider done");
    setc(0, 3, 0, 1'b0);
    wr(A_MASK, 32'h8);
    setc(2, 0, 1, 1'b1);
    wr(A_CNT, 32'hFFFF);
    rd(A_STAT, 32'h0, "status");
    ticks(1, 1);
    rd(A_CNT, 32'h0, "count");
    rd(A_STAT, 32'h8, "status");
    chk("irq", 32'h1, {31'h0, irq});
    rd(A_VEC, {28'h0, CTC_VEC_OVF}, "vector");
    wr(A_STAT, 32'h8);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test overflow done");
    setc(0, 0, 1, 1'b0);
    wr(A_PER, 32'h3);
    rd(A_PER, 32'h3, "period");
    setc(1, 0, 2, 1'b1);
    rd(A_CTRL, 32'h21, "ctrl");
    ticks(2, 5);
    setc(0, 0, 2, 1'b0);
    rd(A_CNT, 32'h1, "count");
    rd(A_STAT, 32'h8, "status");
    wr(A_STAT, 32'h8);
    wr(A_PER, 32'h2);
    setc(3, 0, 3, 1'b1);
    ticks(3, 3);
    chk("count_value", 32'h1, {16'h0, count_value});
    chk("count_down", 32'h1, {31'h0, count_down});
    rd(A_STAT, 32'h0, "status");
    setc(0, 0, 3, 1'b0);
    setc(3, 0, 3, 1'b0);
    ticks(3, 1);
    rd(A_CNT, 32'h0, "count");
    rd(A_STAT, 32'h8, "status");
    ticks(3, 3);
    setc(0, 0, 3, 1'b1);
    @(posedge ref_clk);
    chk("count_value", 32'h0, {16'h0, count_value});
    chk("count_down", 32'h0, {31'h0, count_down});
    $display("test up and updown done");
    wr(A_STAT, 32'hF);
    wr(A_MASK, 32'hF);
    rd(A_MASK, 32'hF, "mask");
    chan(3'b110);
    rd(A_STAT, 32'h6, "status");
    rd(A_VEC, 32'h4, "vector");
    wr(A_STAT, 32'h2);
    rd(A_VEC, 32'h6, "vector");
    chan(3'b001);
    rd(A_VEC, 32'h2, "vector");
    chk("irq", 32'h1, {31'h0, irq});
    wr(A_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test channels done");
    summarize();
  end
endmodule // tb_ctc_core
